// >>> bench/sflf_check_bench.sv
// Self-checking bench for the store-to-load forward check
`timescale 1ns/100ps
`default_nettype none
module sflf_check_bench;
	import sflf_pkg::*;
	logic          clk_i = 1'b0;
	logic          sys_rst_i = 1'b1;
	logic          strict_mode_i = 1'b1;
	logic          slow = 1'b0;
	logic          st_commit_i;
	sflf_acc_s     st_alloc_i = '0;
	sflf_idx_evt_s st_data_i = '0;
	sflf_idx_evt_s st_retire_i = '0;
	sflf_ld_req_s  ld_req_i = '0;
	sflf_resp_s    ld_resp_o;
	logic [2:0]    st_tail_o;
	logic          st_full_o;
	logic          st_drain_ok_o;
	logic          ld_rdy_o;
	logic [2:0]    tl = '0;
	logic [31:0]   base = 32'h40;
	int            errors = 0;
	int            comparisons = 0;
	int            cyc = 0;
	sflf_check u_sflf_check (.clk_i, .sys_rst_i, .strict_mode_i,
		.st_alloc_i, .st_data_i, .st_retire_i, .st_commit_i, .st_tail_o,
		.st_full_o, .st_drain_ok_o, .ld_req_i, .ld_rdy_o, .ld_resp_o);
	sflf_drain_model u_sflf_drain_model (.clk_i, .sys_rst_i, .slow_i(slow),
		.drain_ok_i(st_drain_ok_o), .commit_o(st_commit_i));
	initial forever #5 clk_i = ~clk_i;
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h exp %h", $time, g, e);
		end
	endtask
	task automatic alloc(input logic [31:0] a, input sflf_size_t s);
		@(posedge clk_i);
		st_alloc_i <= '{1'b1, a, s};
		@(posedge clk_i);
		st_alloc_i.vld <= 1'b0;
		tl++;
	endtask
	// Data written (r=0) or retired (r=1) for entry i
	task automatic ev(input logic r, input logic [2:0] i);
		@(posedge clk_i);
		if (r) st_retire_i <= '{1'b1, i};
		else st_data_i <= '{1'b1, i};
		@(posedge clk_i);
		st_retire_i.vld <= 1'b0;
		st_data_i.vld <= 1'b0;
	endtask
	task automatic ld(input logic [3:0] t, input logic [31:0] a,
			input sflf_size_t s);
		@(posedge clk_i);
		ld_req_i <= '{1'b1, t, a, s};
		do @(posedge clk_i); while (ld_rdy_o !== 1'b1);
		ld_req_i.vld <= 1'b0;
	endtask
	task automatic got(input logic [3:0] t, input logic s,
			input logic [2:0] i, input logic [2:0] o);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ld_resp_o.vld !== 1'b1 && n < 60);
		cmp({ld_resp_o.vld, ld_resp_o.tag, ld_resp_o.src}, {1'b1, t, s});
		if (s) cmp({ld_resp_o.idx, ld_resp_o.off}, {i, o});
	endtask
	task automatic quiet(input int n);
		repeat (n) begin
			@(posedge clk_i);
			cmp(ld_resp_o.vld, 1'b0);
		end
	endtask
	// One store at base, one load at offset lo; f: forward expected
	task automatic one(input logic m, input sflf_size_t ss,
			input sflf_size_t ls, input logic [2:0] lo, input logic f);
		logic [2:0] i;
		i = tl;
		cmp(st_tail_o, tl);
		strict_mode_i <= m;
		alloc(base, ss);
		ev(1'b0, i);
		ld(4'h1, base + 32'(lo), ls);
		if (f) begin
			got(4'h1, 1'b1, i, lo);
			ev(1'b1, i);
		end else begin
			quiet(8);
			ev(1'b1, i);
			got(4'h1, 1'b0, 3'h0, 3'h0);
		end
		repeat (6) @(posedge clk_i);
	endtask
	// Blocked older load is passed; unrelated load runs free
	task automatic pass_by;
		logic [2:0] i;
		i = tl;
		strict_mode_i <= 1'b1;
		alloc(32'h80, SZ_32);
		ld(4'h2, 32'h81, SZ_8);
		ld(4'h3, 32'h80, SZ_8);
		ld(4'h4, 32'h900, SZ_8);
		got(4'h4, 1'b0, 3'h0, 3'h0);
		quiet(3);
		ev(1'b0, i);
		got(4'h3, 1'b1, i, 3'h0);
		ev(1'b1, i);
		got(4'h2, 1'b0, 3'h0, 3'h0);
		repeat (6) @(posedge clk_i);
	endtask
	// Four byte stores never serve a dword; a younger dword does
	task automatic pieces;
		logic [2:0] i;
		i = tl;
		strict_mode_i <= 1'b0;
		slow <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			alloc(32'hc0 + k, SZ_8);
			ev(1'b0, 3'(i + k));
		end
		ld(4'h5, 32'hc0, SZ_32);
		quiet(8);
		alloc(32'hc0, SZ_32);
		ev(1'b0, 3'(i + 4));
		ld(4'h6, 32'hc0, SZ_32);
		got(4'h6, 1'b1, 3'(i + 4), 3'h0);
		for (int k = 0; k < 4; k++) ev(1'b1, 3'(i + k));
		got(4'h5, 1'b0, 3'h0, 3'h0);
		slow <= 1'b0;
		ev(1'b1, 3'(i + 4));
		repeat (20) @(posedge clk_i);
	endtask
	// Full buffer drops a store; drain waits for retirement
	task automatic fill;
		logic [2:0] i;
		i = tl;
		for (int k = 0; k < 8; k++) alloc(32'h1000 + 32'(k * 8), SZ_64);
		@(posedge clk_i);
		cmp(st_full_o, 1'b1);
		alloc(32'h2000, SZ_64);
		tl--;
		@(posedge clk_i);
		cmp(st_tail_o, tl);
		ev(1'b0, i);
		@(posedge clk_i);
		cmp(st_drain_ok_o, 1'b0);
		ev(1'b1, i);
		@(posedge clk_i);
		cmp(st_drain_ok_o, 1'b1);
		for (int k = 1; k < 8; k++) begin
			ev(1'b0, 3'(i + k));
			ev(1'b1, 3'(i + k));
		end
		repeat (20) @(posedge clk_i);
		cmp({st_full_o, st_drain_ok_o}, 2'h0);
	endtask
	task automatic stop_test;
		$display("errors %0d comparisons %0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors++;
			stop_test;
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		one(1'b1, SZ_32, SZ_8, 3'h0, 1'b1);
		one(1'b1, SZ_32, SZ_8, 3'h3, 1'b0);
		one(1'b1, SZ_64, SZ_16, 3'h2, 1'b0);
		one(1'b1, SZ_64, SZ_16, 3'h4, 1'b0);
		one(1'b1, SZ_8, SZ_16, 3'h0, 1'b0);
		one(1'b0, SZ_16, SZ_16, 3'h0, 1'b1);
		one(1'b0, SZ_16, SZ_8, 3'h1, 1'b0);
		one(1'b0, SZ_32, SZ_16, 3'h2, 1'b1);
		one(1'b0, SZ_32, SZ_8, 3'h2, 1'b0);
		one(1'b0, SZ_64, SZ_32, 3'h4, 1'b1);
		one(1'b0, SZ_64, SZ_32, 3'h2, 1'b0);
		one(1'b0, SZ_64, SZ_64, 3'h0, 1'b1);
		one(1'b0, SZ_64, SZ_16, 3'h4, 1'b0);
		// Unaligned store falls back to the strict rule
		base = 32'h42;
		one(1'b0, SZ_32, SZ_16, 3'h2, 1'b0);
		base = 32'h40;
		pass_by;
		pieces;
		fill;
		stop_test;
	end
endmodule // sflf_check_bench
bind sflf_check sflf_check_monitor u_mon (.clk_i, .sys_rst_i,
	.strict_mode_i, .st_alloc_i, .st_data_i, .st_retire_i, .st_commit_i,
	.st_tail_o, .st_full_o, .st_drain_ok_o, .ld_req_i, .ld_rdy_o,
	.ld_resp_o);
`default_nettype wire

// >>> bench/sflf_check_monitor.sv
// Port assertions for the store-to-load forward check
`timescale 1ns/100ps
`default_nettype none
module sflf_check_monitor (
	// Clock and reset
	input wire logic                       clk_i,
	input wire logic                       sys_rst_i,
	// Watched ports
	input wire logic                       strict_mode_i,
	input wire sflf_pkg::sflf_acc_s        st_alloc_i,
	input wire sflf_pkg::sflf_idx_evt_s    st_data_i,
	input wire sflf_pkg::sflf_idx_evt_s    st_retire_i,
	input wire logic                       st_commit_i,
	input wire logic [sflf_pkg::SB_IW-1:0] st_tail_o,
	input wire logic                       st_full_o,
	input wire logic                       st_drain_ok_o,
	input wire sflf_pkg::sflf_ld_req_s     ld_req_i,
	input wire logic                       ld_rdy_o,
	input wire sflf_pkg::sflf_resp_s       ld_resp_o
);
	import sflf_pkg::*;
	// Per entry: data written, retired; cleared on reuse
	logic [SB_N-1:0] dat_reg;
	logic [SB_N-1:0] ret_reg;
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			dat_reg <= '0;
			ret_reg <= '0;
		end else begin
			if (st_alloc_i.vld && !st_full_o) begin
				dat_reg[st_tail_o] <= 1'b0;
				ret_reg[st_tail_o] <= 1'b0;
			end
			if (st_data_i.vld)
				dat_reg[st_data_i.idx] <= 1'b1;
			if (st_retire_i.vld)
				ret_reg[st_retire_i.idx] <= 1'b1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	chk_resp_early: assert property (
		ld_req_i.vld && ld_rdy_o |=> !(ld_resp_o.vld &&
		ld_resp_o.tag == $past(ld_req_i.tag))) else $error("early answer");
	chk_fwd_data: assert property (
		ld_resp_o.vld && ld_resp_o.src |-> dat_reg[ld_resp_o.idx])
		else $error("forward before data");
	chk_strict_start: assert property (
		ld_resp_o.vld && ld_resp_o.src && strict_mode_i |->
		ld_resp_o.off == 3'h0) else $error("strict forward off start");
	chk_fwd_even: assert property (
		ld_resp_o.vld && ld_resp_o.src |-> !ld_resp_o.off[0])
		else $error("forward at odd offset");
	chk_drain_ret: assert property (
		st_drain_ok_o |-> |(dat_reg & ret_reg))
		else $error("drain before retire");
	chk_tail_step: assert property (
		st_alloc_i.vld && !st_full_o |=> st_tail_o == $past(st_tail_o) + 3'h1)
		else $error("tail did not step");
	chk_tail_hold: assert property (
		!(st_alloc_i.vld && !st_full_o) |=> $stable(st_tail_o))
		else $error("tail moved");
	chk_resp_once: assert property (
		ld_resp_o.vld |=> !(ld_resp_o.vld &&
		ld_resp_o.tag == $past(ld_resp_o.tag))) else $error("answer repeated");
endmodule // sflf_check_monitor
`default_nettype wire

// >>> bench/sflf_drain_model.sv
// Drain side model: commits the head store, fast or slow
`timescale 1ns/100ps
`default_nettype none
module sflf_drain_model (
	// Clock and reset
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	// Pacing and status
	input  wire logic slow_i,
	input  wire logic drain_ok_i,
	// Commit pulse
	output logic      commit_o
);
	logic [1:0] wait_reg;
	// Pulse never repeats: status needs one cycle to update
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || commit_o) begin
			commit_o <= 1'b0;
			wait_reg <= '0;
		end else if (drain_ok_i) begin
			if (slow_i && wait_reg != 2'h3)
				wait_reg <= wait_reg + 2'h1;
			else
				commit_o <= 1'b1;
		end
	end
endmodule // sflf_drain_model
`default_nettype wire

// >>> core/sflf_check.sv
// Store buffer tracking and load forward / stall decision
`timescale 1ns/100ps
`default_nettype none

module sflf_check (
	// Clock and reset
	input  wire logic                 clk_i,
	input  wire logic                 sys_rst_i,
	// Mode
	input  wire logic                 strict_mode_i,
	// Store buffer events
	input  wire sflf_pkg::sflf_acc_s     st_alloc_i,
	input  wire sflf_pkg::sflf_idx_evt_s st_data_i,
	input  wire sflf_pkg::sflf_idx_evt_s st_retire_i,
	input  wire logic                 st_commit_i,
	// Store buffer status
	output logic [sflf_pkg::SB_IW-1:0] st_tail_o,
	output logic                      st_full_o,
	output logic                      st_drain_ok_o,
	// Loads
	input  wire sflf_pkg::sflf_ld_req_s  ld_req_i,
	output logic                      ld_rdy_o,
	output sflf_pkg::sflf_resp_s      ld_resp_o
);
	import sflf_pkg::*;

	typedef struct packed {
		sflf_sb_ent_s [SB_N-1:0] sb;
		sflf_lq_ent_s [LQ_N-1:0] lq;
		logic [SB_IW-1:0]        head;
		logic [SB_IW-1:0]        tail;
		logic                    full;
		logic                    drain;
		logic                    ld_rdy;
		sflf_resp_s              resp;
	} sflf_state_s;

	sflf_state_s r_reg;
	sflf_state_s r_next;

	// Youngest overlapping store search
	logic                hit;
	logic [SB_IW-1:0]    sel;
	logic [SB_N-1:0]     ovl_mask;
	logic [SB_IW-1:0]    sidx;
	logic                fwd_ok;
	logic [2:0]          fwd_off;

	always_comb begin
		hit      = 1'b0;
		sel      = '0;
		ovl_mask = '0;
		sidx     = '0;
		// Walk oldest to youngest so the last hit is the youngest
		for (int i = 0; i < SB_N; i++) begin
			sidx = r_reg.head + SB_IW'(i);
			if (r_reg.sb[sidx].vld && overlaps(r_reg.sb[sidx].addr,
					r_reg.sb[sidx].size, ld_req_i.addr,
					ld_req_i.size)) begin
				hit           = 1'b1;
				sel           = sidx;
				ovl_mask[sidx] = 1'b1;
			end
		end
	end

	sflf_decide u_decide (
		.strict_i  (strict_mode_i),
		.st_addr_i (r_reg.sb[sel].addr),
		.st_size_i (r_reg.sb[sel].size),
		.ld_addr_i (ld_req_i.addr),
		.ld_size_i (ld_req_i.size),
		.fwd_ok_o  (fwd_ok),
		.off_o     (fwd_off)
	);

	logic               taken;
	logic               issued;
	logic               commit;
	logic               slot_rdy;
	logic [SB_IW-1:0]   h;

	always_comb begin
		r_next          = r_reg;
		r_next.resp.vld = 1'b0;
		taken           = 1'b0;
		issued          = 1'b0;
		slot_rdy        = 1'b0;
		h               = r_reg.head;
		// One completion per cycle, in any age order
		for (int j = 0; j < LQ_N; j++) begin
			case (r_reg.lq[j].st)
			LQ_READY:     slot_rdy = 1'b1;
			LQ_WAIT_DATA: slot_rdy = r_reg.sb[r_reg.lq[j].idx].data_ok;
			LQ_WAIT_MEM:  slot_rdy = (r_reg.lq[j].wait_mask == '0);
			default:      slot_rdy = 1'b0;
			endcase
			if (slot_rdy && !taken) begin
				taken            = 1'b1;
				r_next.resp.vld  = 1'b1;
				r_next.resp.tag  = r_reg.lq[j].tag;
				r_next.resp.src  = r_reg.lq[j].src;
				r_next.resp.idx  = r_reg.lq[j].idx;
				r_next.resp.off  = r_reg.lq[j].off;
				r_next.lq[j].st  = LQ_FREE;
			end
		end
		// Admit a new load into the first free slot
		if (ld_req_i.vld && r_reg.ld_rdy) begin
			for (int j = 0; j < LQ_N; j++) begin
				if (r_reg.lq[j].st == LQ_FREE && !issued) begin
					issued                  = 1'b1;
					r_next.lq[j].tag        = ld_req_i.tag;
					r_next.lq[j].idx        = sel;
					r_next.lq[j].off        = fwd_off;
					r_next.lq[j].wait_mask  = '0;
					if (!hit) begin
						// No dependence: straight to cache
						r_next.lq[j].st  = LQ_READY;
						r_next.lq[j].src = SRC_CACHE;
					end else if (fwd_ok) begin
						r_next.lq[j].st  = LQ_WAIT_DATA;
						r_next.lq[j].src = SRC_FWD;
					end else begin
						// Partial, multi-store or disallowed-offset cover blocks
						r_next.lq[j].st        = LQ_WAIT_MEM;
						r_next.lq[j].src       = SRC_CACHE;
						r_next.lq[j].wait_mask = ovl_mask;
					end
				end
			end
		end
		// Data and retirement marks
		if (st_data_i.vld) begin
			r_next.sb[st_data_i.idx].data_ok = 1'b1;
		end
		if (st_retire_i.vld) begin
			r_next.sb[st_retire_i.idx].retired = 1'b1;
		end
		// Drain head only once retired and data present
		commit = st_commit_i && r_reg.drain;
		if (commit) begin
			r_next.sb[h].vld     = 1'b0;
			r_next.sb[h].data_ok = 1'b0;
			r_next.sb[h].retired = 1'b0;
			r_next.head          = h + SB_IW'(1);
			for (int j = 0; j < LQ_N; j++) begin
				r_next.lq[j].wait_mask[h] = 1'b0;
				// Source gone to cache; entry index may be reused
				if (r_next.lq[j].st == LQ_WAIT_DATA
						&& r_next.lq[j].idx == h) begin
					r_next.lq[j].st  = LQ_READY;
					r_next.lq[j].src = SRC_CACHE;
				end
			end
		end
		// Allocation is dropped while full
		if (st_alloc_i.vld && !r_reg.full) begin
			r_next.sb[r_reg.tail].vld     = 1'b1;
			r_next.sb[r_reg.tail].data_ok = 1'b0;
			r_next.sb[r_reg.tail].retired = 1'b0;
			r_next.sb[r_reg.tail].addr    = st_alloc_i.addr;
			r_next.sb[r_reg.tail].size    = st_alloc_i.size;
			r_next.tail                   = r_reg.tail + SB_IW'(1);
		end
		r_next.full   = r_next.sb[r_next.tail].vld;
		r_next.drain  = r_next.sb[r_next.head].vld
			&& r_next.sb[r_next.head].retired
			&& r_next.sb[r_next.head].data_ok;
		r_next.ld_rdy = 1'b0;
		for (int j = 0; j < LQ_N; j++) begin
			if (r_next.lq[j].st == LQ_FREE) begin
				r_next.ld_rdy = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end

	assign st_tail_o     = r_reg.tail;
	assign st_full_o     = r_reg.full;
	assign st_drain_ok_o = r_reg.drain;
	assign ld_rdy_o      = r_reg.ld_rdy;
	assign ld_resp_o     = r_reg.resp;
endmodule // sflf_check

`default_nettype wire

// >>> core/sflf_decide.sv
// Package for the store-to-load forward check and its decision module
`timescale 1ns/100ps
`default_nettype none

package sflf_pkg;
	localparam int AW     = 32;
	localparam int SB_N   = 8;
	localparam int SB_IW  = 3;
	localparam int LQ_N   = 4;
	localparam int TAG_W  = 4;

	// Access size, log2 of the byte count
	typedef logic [1:0] sflf_size_t;
	localparam sflf_size_t SZ_8  = 2'h0;
	localparam sflf_size_t SZ_16 = 2'h1;
	localparam sflf_size_t SZ_32 = 2'h2;
	localparam sflf_size_t SZ_64 = 2'h3;

	// Load offsets inside a store that the relaxed table allows
	localparam logic [2:0] OFF_WORD_IN_DWORD = 3'h2;
	localparam logic [2:0] OFF_DWORD_IN_QWORD = 3'h4;

	// Where a load takes its data from
	localparam logic SRC_CACHE = 1'b0;
	localparam logic SRC_FWD   = 1'b1;

	typedef enum logic [1:0] {
		LQ_FREE,
		LQ_READY,
		LQ_WAIT_DATA,
		LQ_WAIT_MEM
	} sflf_lq_state_e;

	typedef struct packed {
		logic              vld;
		logic [AW-1:0]     addr;
		sflf_size_t        size;
	} sflf_acc_s;

	typedef struct packed {
		logic              vld;
		logic [TAG_W-1:0]  tag;
		logic [AW-1:0]     addr;
		sflf_size_t        size;
	} sflf_ld_req_s;

	typedef struct packed {
		logic              vld;
		logic [SB_IW-1:0]  idx;
	} sflf_idx_evt_s;

	typedef struct packed {
		logic              vld;
		logic [TAG_W-1:0]  tag;
		logic              src;
		logic [SB_IW-1:0]  idx;
		logic [2:0]        off;
	} sflf_resp_s;

	typedef struct packed {
		logic              vld;
		logic              data_ok;
		logic              retired;
		logic [AW-1:0]     addr;
		sflf_size_t        size;
	} sflf_sb_ent_s;

	typedef struct packed {
		sflf_lq_state_e    st;
		logic [TAG_W-1:0]  tag;
		logic              src;
		logic [SB_IW-1:0]  idx;
		logic [2:0]        off;
		logic [SB_N-1:0]   wait_mask;
	} sflf_lq_ent_s;

	function automatic logic [AW:0] size_bytes(input sflf_size_t s);
		size_bytes = (AW+1)'(1) << s;
	endfunction

	function automatic logic overlaps(input logic [AW-1:0] a1,
			input sflf_size_t s1, input logic [AW-1:0] a2,
			input sflf_size_t s2);
		logic [AW:0] e1;
		logic [AW:0] e2;
		e1 = {1'b0, a1} + size_bytes(s1);
		e2 = {1'b0, a2} + size_bytes(s2);
		overlaps = ({1'b0, a1} < e2) && ({1'b0, a2} < e1);
	endfunction
endpackage

module sflf_decide (
	// Mode
	input  wire logic             strict_i,
	// Candidate store
	input  wire logic [sflf_pkg::AW-1:0] st_addr_i,
	input  wire sflf_pkg::sflf_size_t    st_size_i,
	// Load
	input  wire logic [sflf_pkg::AW-1:0] ld_addr_i,
	input  wire sflf_pkg::sflf_size_t    ld_size_i,
	// Verdict
	output logic                  fwd_ok_o,
	output logic [2:0]            off_o
);
	import sflf_pkg::*;

	logic [AW:0] st_end;
	logic [AW:0] ld_end;
	logic        contained;
	logic        same_start;
	logic        natural;
	logic [AW-1:0] diff;
	logic [AW:0] st_bytes;

	always_comb begin
		st_end     = {1'b0, st_addr_i} + size_bytes(st_size_i);
		ld_end     = {1'b0, ld_addr_i} + size_bytes(ld_size_i);
		contained  = (ld_addr_i >= st_addr_i) && (ld_end <= st_end);
		same_start = (ld_addr_i == st_addr_i);
		diff       = ld_addr_i - st_addr_i;
		off_o      = diff[2:0];
		st_bytes   = size_bytes(st_size_i);
		natural    = ((st_addr_i[2:0] & (st_bytes[2:0] - 3'h1)) == 3'h0);
		if (strict_i || !natural) begin
			// Strict: only same start, so byte 1..3 of a dword and
			// words at 2 or 4 of a qword stall
			fwd_ok_o = contained && same_start;
		end else begin
			fwd_ok_o = contained && (same_start
				|| (ld_size_i == SZ_16 && st_size_i == SZ_32
				&& off_o == OFF_WORD_IN_DWORD)
				|| (ld_size_i == SZ_32 && st_size_i == SZ_64
				&& off_o == OFF_DWORD_IN_QWORD));
		end
	end
endmodule // sflf_decide

`default_nettype wire
